// File: lcp_rx_consts.vh
// Constants of the receive-side content-protection controller.
// Assumes inclusion by bare name from the design file.
`ifndef LCP_RX_CONSTS_VH
`define LCP_RX_CONSTS_VH
// Register byte offsets
`define LCP_OFF_CTRL 8'h00
`define LCP_OFF_STATUS 8'h04
`define LCP_OFF_SESS_LO 8'h08
`define LCP_OFF_SESS_HI 8'h0C
`define LCP_OFF_TXKSV_LO 8'h10
`define LCP_OFF_TXKSV_HI 8'h14
`define LCP_OFF_RXKSV_LO 8'h18
`define LCP_OFF_RXKSV_HI 8'h1C
`define LCP_OFF_RX_RESP 8'h20
`define LCP_OFF_RX_ENH 8'h24
`define LCP_OFF_HASH_CTRL 8'h28
`define LCP_OFF_HASH_BUF 8'h40
`define LCP_OFF_DIGEST 8'h80
// Control bit positions and control reset value
`define LCP_CTRL_ENC 0
`define LCP_CTRL_REPEATER 1
`define LCP_CTRL_INTCMP 2
`define LCP_CTRL_DEVOVF 3
`define LCP_CTRL_RESET 4'h4
`define LCP_HASH_INIT 0
`define LCP_HASH_GO 1
// Counts in reference clocks and video frames, key ones and hash rounds
`define LCP_RESP_DEADLINE 8'd128
`define LCP_CALC_CYCLES 8'd64
`define LCP_REGEN_FRAMES 7'h7F
`define LCP_ENH_FRAMES 4'hF
`define LCP_KSV_ONES 6'd20
`define LCP_SHA_LAST 7'd79
// Hash initial state and round constants
`define LCP_H0 32'h67452301
`define LCP_H1 32'hEFCDAB89
`define LCP_H2 32'h98BADCFE
`define LCP_H3 32'h10325476
`define LCP_H4 32'hC3D2E1F0
`define LCP_K0 32'h5A827999
`define LCP_K1 32'h6ED9EBA1
`define LCP_K2 32'h8F1BBCDC
`define LCP_K3 32'hCA62C1D6
`endif

// File: lcp_rx_ctrl.v
// Receive-side content-protection controller with APB register access.
// Assumes sync inputs from another clock domain and OTP words stable after reset.
`timescale 1ns/1ps
`include "lcp_rx_consts.vh"

// Notes on behaviour
// [R1] Host starts session at the serializer
// [R2] Host copies 64-bit session random here
// [R3] Host exchanges key vectors, checks revocation
// [R4] Compute 16-bit response, host-readable
// [R5] Response ready within 128 clocks
// [R6] Comparison-mode bit: 1 internal, 0 host
// [R7] Internal mode: serializer compares copied response
// [R8] Key vector needs twenty ones; flag otherwise
// [R9] Host resamples, then resets protection
// [R10] Revoked key: host sends no protected content
// [R11] Host checks integrity every 128 frames
// [R12] Regenerate response every 128 frames
// [R13] 8-bit enhanced value every 16 frames
// [R14] Host resamples after three enhanced mismatches
// [R15] Host writes both enables in one frame
// [R16] Enable bit encrypts regardless of content
// [R17] Authenticate before enable, disable before restart
// [R18] Start on vsync, rekey each sync fall; cipherKey holds through a response calculation, rekeyPulse still fires
// [R19] Host sets repeater bit on repeaters
// [R20] Hash the assembled key vector list
// [R21] Host flags more than fourteen downstream receivers
// [R22] Secret keyset from one-time storage
// [R23] Host restarts on lost synchronisation
// [R24] Transmitter key write triggers response computation
// [R25] Response held until next regeneration
module lcp_rx_ctrl (
   // Clock, reset, enable
   input wire ref_clk,
   input wire reset_n,
   input wire clkEn,
   // APB slave
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Internal sync levels from the video path
   input wire vsyncIn,
   input wire hsyncIn,
   // One-time storage contents
   input wire [39:0] otpRxKsv,
   input wire [63:0] otpSecret,
   // Cipher side
   output reg encryptActive,
   output reg rekeyPulse,
   output reg [31:0] cipherKey
);

   reg [3:0] ctrl;
   reg [63:0] session;
   reg [39:0] txKsv;
   reg [63:0] cState;
   reg [7:0] calcCnt;
   reg calcBusy;
   reg respValid;
   reg [15:0] rxResp;
   reg [7:0] rxEnh;
   reg [6:0] frameCnt;
   reg [2:0] vsSync;
   reg [2:0] hsSync;
   reg [31:0] wBuf [0:15];
   reg [31:0] hReg [0:4];
   reg [31:0] shA, shB, shC, shD, shE;
   reg [6:0] shRound;
   reg shBusy;
   reg [31:0] next_rdata;
   reg next_err;
   reg [5:0] onesCnt;
   reg [31:0] shF;
   reg [31:0] shK;
   integer i;
   integer j;

   wire apbAccess = psel & penable & ~pready;
   wire wrDone = psel & penable & pready & pwrite;
   wire vsFall = vsSync[2] & ~vsSync[1];
   wire hsFall = hsSync[2] & ~hsSync[1];
   wire keyInvalid = (onesCnt != `LCP_KSV_ONES);
   wire [63:0] stepState = {cState[62:0], cState[63] ^ cState[62] ^ cState[60] ^ cState[59]}
      ^ {48'h0, cState[63:48]};
   wire [3:0] rI = shRound[3:0];
   wire [3:0] i13 = rI + 4'hD;
   wire [3:0] i8 = rI + 4'h8;
   wire [3:0] i2 = rI + 4'h2;
   wire [31:0] wMix = wBuf[i13] ^ wBuf[i8] ^ wBuf[i2] ^ wBuf[rI];
   wire [31:0] wT = (shRound < 7'd16) ? wBuf[rI] : {wMix[30:0], wMix[31]};
   wire [31:0] shTemp = {shA[26:0], shA[31:27]} + shF + shE + shK + wT;

   // Balance check of the receiver key vector
   always @* begin
      onesCnt = 6'h00;
      for (i = 0; i < 40; i = i + 1) begin
         onesCnt = onesCnt + {5'h00, otpRxKsv[i]}; // [R8]
      end
   end

   // Round function selection
   always @* begin
      if (shRound < 7'd20) begin
         shF = (shB & shC) | (~shB & shD);
         shK = `LCP_K0;
      end else if (shRound < 7'd40) begin
         shF = shB ^ shC ^ shD;
         shK = `LCP_K1;
      end else if (shRound < 7'd60) begin
         shF = (shB & shC) | (shB & shD) | (shC & shD);
         shK = `LCP_K2;
      end else begin
         shF = shB ^ shC ^ shD;
         shK = `LCP_K3;
      end
   end

   // Read mux; unmapped addresses answer with an error
   always @* begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr >= `LCP_OFF_HASH_BUF && paddr < `LCP_OFF_DIGEST) begin
         next_rdata = wBuf[paddr[5:2]];
      end else if (paddr >= `LCP_OFF_DIGEST && paddr < 8'h94) begin
         next_rdata = hReg[paddr[4:2]];
      end else begin
         case (paddr)
            `LCP_OFF_CTRL: next_rdata = {28'h0, ctrl};
            `LCP_OFF_STATUS: next_rdata = {27'h0, shBusy, calcBusy, respValid,
               encryptActive, keyInvalid}; // [R8]
            `LCP_OFF_SESS_LO: next_rdata = session[31:0];
            `LCP_OFF_SESS_HI: next_rdata = session[63:32];
            `LCP_OFF_TXKSV_LO: next_rdata = txKsv[31:0];
            `LCP_OFF_TXKSV_HI: next_rdata = {24'h0, txKsv[39:32]};
            `LCP_OFF_RXKSV_LO: next_rdata = otpRxKsv[31:0];
            `LCP_OFF_RXKSV_HI: next_rdata = {24'h0, otpRxKsv[39:32]};
            `LCP_OFF_RX_RESP: next_rdata = {16'h0, rxResp}; // [R4] [R7]
            `LCP_OFF_RX_ENH: next_rdata = {24'h0, rxEnh}; // [R13]
            `LCP_OFF_HASH_CTRL: next_rdata = {31'h0, shBusy};
            default: next_err = 1'b1;
         endcase
      end
   end

   // APB handshake: one wait state, so every transfer takes three enabled cycles, setup included
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready <= apbAccess;
         if (apbAccess) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= next_err;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Sync inputs cross in through two flops; the third holds the old level
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         vsSync <= 3'h0;
         hsSync <= 3'h0;
      end else if (clkEn) begin
         vsSync <= {vsSync[1:0], vsyncIn};
         hsSync <= {hsSync[1:0], hsyncIn};
      end
   end

   // Control, session words and encryption framing
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= `LCP_CTRL_RESET;
         session <= 64'h0;
         txKsv <= 40'h0;
         encryptActive <= 1'b0;
         rekeyPulse <= 1'b0;
         frameCnt <= 7'h00;
      end else if (clkEn) begin
         if (wrDone) begin
            case (paddr)
               `LCP_OFF_CTRL: ctrl <= pwdata[3:0]; // [R6]
               `LCP_OFF_SESS_LO: session[31:0] <= pwdata;
               `LCP_OFF_SESS_HI: session[63:32] <= pwdata;
               `LCP_OFF_TXKSV_LO: txKsv[31:0] <= pwdata;
               `LCP_OFF_TXKSV_HI: txKsv[39:32] <= pwdata[7:0];
               default: ;
            endcase
         end
         // Enable changes only at a frame boundary so both ends switch together
         if (vsFall) begin
            encryptActive <= ctrl[`LCP_CTRL_ENC]; // [R18] [R16]
            frameCnt <= encryptActive ? frameCnt + 7'h01 : 7'h00;
         end
         rekeyPulse <= encryptActive & (vsFall | hsFall); // [R18]
      end
   end

   // Response computation and cipher stand-in state
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cState <= 64'h0;
         calcCnt <= 8'h00;
         calcBusy <= 1'b0;
         respValid <= 1'b0;
         rxResp <= 16'h0000;
         rxEnh <= 8'h00;
         cipherKey <= 32'h0000_0000;
      end else if (clkEn) begin
         if (wrDone && paddr == `LCP_OFF_TXKSV_HI) begin
            // Secret keyset mixes with session and peer vector
            cState <= otpSecret ^ session ^ {24'h0, pwdata[7:0], txKsv[31:0]}; // [R24] [R22]
            calcCnt <= 8'h00;
            calcBusy <= 1'b1;
            respValid <= 1'b0;
         end else if (calcBusy) begin
            cState <= stepState;
            calcCnt <= calcCnt + 8'h01;
            // Finishes well inside the deadline of LCP_RESP_DEADLINE
            if (calcCnt == `LCP_CALC_CYCLES - 8'h01) begin
               calcBusy <= 1'b0;
               respValid <= 1'b1;
               rxResp <= stepState[15:0]; // [R4] [R5]
            end
         end else if (encryptActive && vsFall && frameCnt == `LCP_REGEN_FRAMES) begin
            calcCnt <= 8'h00;
            calcBusy <= 1'b1; // [R12] [R25]
            // Frame 127 is also a sixteenth frame; keep the enhanced value on time
            rxEnh <= stepState[23:16]; // [R13]
         end else if (encryptActive && (vsFall || hsFall)) begin
            cState <= stepState;
            cipherKey <= stepState[31:0]; // [R18]
            if (vsFall && frameCnt[3:0] == `LCP_ENH_FRAMES) begin
               rxEnh <= stepState[23:16]; // [R13]
            end
         end
      end
   end

   // Hash engine over the host-assembled key vector list
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (j = 0; j < 16; j = j + 1) begin
            wBuf[j] <= 32'h0000_0000;
         end
         hReg[0] <= `LCP_H0;
         hReg[1] <= `LCP_H1;
         hReg[2] <= `LCP_H2;
         hReg[3] <= `LCP_H3;
         hReg[4] <= `LCP_H4;
         shA <= 32'h0000_0000;
         shB <= 32'h0000_0000;
         shC <= 32'h0000_0000;
         shD <= 32'h0000_0000;
         shE <= 32'h0000_0000;
         shRound <= 7'h00;
         shBusy <= 1'b0;
      end else if (clkEn) begin
         if (shBusy) begin
            // Schedule overwrites the buffer in place; host reloads per block
            wBuf[rI] <= wT; // [R20]
            shA <= shTemp;
            shB <= shA;
            shC <= {shB[1:0], shB[31:2]};
            shD <= shC;
            shE <= shD;
            shRound <= shRound + 7'h01;
            if (shRound == `LCP_SHA_LAST) begin
               shBusy <= 1'b0;
               hReg[0] <= hReg[0] + shTemp;
               hReg[1] <= hReg[1] + shA;
               hReg[2] <= hReg[2] + {shB[1:0], shB[31:2]};
               hReg[3] <= hReg[3] + shC;
               hReg[4] <= hReg[4] + shD;
            end
         end else if (wrDone) begin
            // Writes during a block are dropped
            if (paddr >= `LCP_OFF_HASH_BUF && paddr < `LCP_OFF_DIGEST) begin
               wBuf[paddr[5:2]] <= pwdata;
            end else if (paddr == `LCP_OFF_HASH_CTRL) begin
               if (pwdata[`LCP_HASH_INIT]) begin
                  hReg[0] <= `LCP_H0;
                  hReg[1] <= `LCP_H1;
                  hReg[2] <= `LCP_H2;
                  hReg[3] <= `LCP_H3;
                  hReg[4] <= `LCP_H4;
               end
               if (pwdata[`LCP_HASH_GO]) begin
                  shA <= pwdata[`LCP_HASH_INIT] ? `LCP_H0 : hReg[0];
                  shB <= pwdata[`LCP_HASH_INIT] ? `LCP_H1 : hReg[1];
                  shC <= pwdata[`LCP_HASH_INIT] ? `LCP_H2 : hReg[2];
                  shD <= pwdata[`LCP_HASH_INIT] ? `LCP_H3 : hReg[3];
                  shE <= pwdata[`LCP_HASH_INIT] ? `LCP_H4 : hReg[4];
                  shRound <= 7'h00;
                  shBusy <= 1'b1; // [R20]
               end
            end
         end
      end
   end

endmodule

// File: lcp_rx_ctrl_sva.sv
// Port assertions for the receive-side protection controller.
// Assumes a bind to lcp_rx_ctrl and sync lows lasting several clocks.
`timescale 1ns/1ps
module lcp_rx_ctrl_sva (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   input wire clkEn,
   // APB
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Sync, storage, cipher
   input wire vsyncIn,
   input wire [39:0] otpRxKsv,
   input wire encryptActive,
   input wire rekeyPulse
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence sWait;
      psel && penable && !pready && clkEn;
   endsequence
   sequence sRead(a);
      pready && !pwrite && paddr == a;
   endsequence
   AST_ACCESS_ANSWER: assert property (sWait |=> pready)
      else $error("access phase not answered after one wait");
   AST_READY_PULSE: assert property (pready && clkEn |=> !pready)
      else $error("ready held longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error flag outside an answer");
   AST_UNMAPPED: assert property (pready && paddr == 8'hFC |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_RESP_WIDTH: assert property (sRead(8'h20) |-> prdata[31:16] == 16'h0)
      else $error("response value wider than 16 bits");
   AST_ENH_WIDTH: assert property (sRead(8'h24) |-> prdata[31:8] == 24'h0)
      else $error("enhanced value wider than 8 bits");
   AST_KEY_BALANCE: assert property (sRead(8'h04) |-> prdata[0] == ($countones(otpRxKsv) != 20))
      else $error("key invalid flag wrong");
   AST_ENC_ON_VSYNC: assert property ($changed(encryptActive) |-> !vsyncIn)
      else $error("encryption changed away from vsync");
   AST_REKEY_ACTIVE: assert property (rekeyPulse |-> encryptActive || $past(encryptActive))
      else $error("rekey while encryption idle");
endmodule

bind lcp_rx_ctrl lcp_rx_ctrl_sva chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .vsyncIn(vsyncIn), .otpRxKsv(otpRxKsv),
   .encryptActive(encryptActive), .rekeyPulse(rekeyPulse));

// File: lcp_sync_gen.sv
// Video timing source: 64-clock frames of four 16-clock lines.
// Assumes the same clock and reset as the controller.
`timescale 1ns/1ps
module lcp_sync_gen (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Sync levels
   output wire vsyncIn,
   output wire hsyncIn
);
   logic [5:0] pos;
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pos <= 6'h0;
      end else begin
         pos <= pos + 6'h1;
      end
   end
   // Hsync falls mid-line so no fall shares a clock with vsync
   assign vsyncIn = pos[5:4] != 2'h0;
   assign hsyncIn = !(pos[3:0] >= 4'h6 && pos[3:0] < 4'hA);
endmodule

// File: lcp_rx_ctrl_tb_top.sv
// Self-checking bench for the receive-side protection controller.
// Assumes lcp_rx_ctrl, its bound checker and lcp_sync_gen.
`timescale 1ns/1ps
module lcp_rx_ctrl_tb_top;
   localparam [39:0] rxKey = 40'h00000FFFFF;
   logic ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic clkEn = 1'b1;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, rd, r1;
   logic [31:0] digest [5] = '{32'hA9993E36, 32'h4706816A, 32'hBA3E2571, 32'h7850C26C,
      32'h9CD0D89D};
   wire [31:0] prdata, cipherKey;
   wire pready, pslverr, vsyncIn, hsyncIn, encryptActive, rekeyPulse;
   int miscompares = 0, n_compared = 0, cyc = 0, n, pulses, polls;

   lcp_rx_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vsyncIn(vsyncIn), .hsyncIn(hsyncIn),
      .otpRxKsv(rxKey), .otpSecret(64'h0123456789ABCDEF), .encryptActive(encryptActive),
      .rekeyPulse(rekeyPulse), .cipherKey(cipherKey));
   lcp_sync_gen sync_u (.ref_clk(ref_clk), .reset_n(reset_n), .vsyncIn(vsyncIn),
      .hsyncIn(hsyncIn));

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Whole run is about nine thousand clocks, most of it 128 frames of regeneration
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   task end_sim();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task xfer(input [7:0] a, input w, input [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) miscompares++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task rdChk(input [7:0] a, input [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check(rd, exp);
   endtask
   task waitEnc(input v);
      n = 0;
      while (encryptActive !== v && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      check({31'h0, encryptActive}, {31'h0, v});
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      rdChk(8'h00, 32'h4);
      wr(8'h00, 32'hE);
      rdChk(8'h00, 32'hE);
      wr(8'h00, 32'h4);
      xfer(8'hFC, 1'b0, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      rdChk(8'h18, rxKey[31:0]);
      rdChk(8'h1C, {24'h0, rxKey[39:32]});
      xfer(8'h04, 1'b0, 32'h0);
      check({31'h0, rd[0]}, 32'h0);
      $display("test registers done");
      wr(8'h08, 32'h13579BDF);
      wr(8'h0C, 32'h2468ACE0);
      wr(8'h10, 32'h0F0F0F0F);
      wr(8'h14, 32'h0000000F);
      // Busy just after the key write, settled before 128 clocks have passed
      rdChk(8'h04, 32'h8);
      repeat (116) @(posedge ref_clk);
      rdChk(8'h04, 32'h4);
      xfer(8'h20, 1'b0, 32'h0);
      r1 = rd;
      check(r1 & 32'hFFFF0000, 32'h0);
      repeat (100) @(posedge ref_clk);
      rdChk(8'h20, r1);
      $display("test response done");
      wr(8'h00, 32'h5);
      waitEnc(1'b1);
      @(negedge vsyncIn);
      pulses = 0;
      repeat (256) begin
         @(posedge ref_clk);
         if (rekeyPulse === 1'b1) pulses++;
      end
      check(pulses, 32'h14);
      // Regeneration after 128 frames; old response stays readable meanwhile
      polls = 0;
      do begin
         xfer(8'h04, 1'b0, 32'h0);
         polls++;
      end while (rd[3] !== 1'b1 && polls < 2500);
      check(rd, 32'hE);
      rdChk(8'h20, r1);
      repeat (70) @(posedge ref_clk);
      rdChk(8'h04, 32'h6);
      xfer(8'h24, 1'b0, 32'h0);
      check(rd & 32'hFFFFFF00, 32'h0);
      wr(8'h00, 32'h4);
      waitEnc(1'b0);
      $display("test encryption done");
      for (int i = 0; i < 16; i++)
         wr(8'(8'h40 + 4 * i), i == 0 ? 32'h61626380 : (i == 15 ? 32'h18 : 32'h0));
      wr(8'h28, 32'h3);
      // A low clock enable must stall the rounds
      clkEn <= 1'b0;
      repeat (85) @(posedge ref_clk);
      clkEn <= 1'b1;
      rdChk(8'h28, 32'h1);
      repeat (90) @(posedge ref_clk);
      for (int i = 0; i < 5; i++)
         rdChk(8'(8'h80 + 4 * i), digest[i]);
      $display("test hash done");
      // Restart as after a lost link
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check({31'h0, pready | encryptActive | rekeyPulse}, 32'h0);
      reset_n <= 1'b1;
      rdChk(8'h00, 32'h4);
      rdChk(8'h80, 32'h67452301);
      $display("test restart done");
      end_sim();
   end
endmodule
